// [common/rstseq_pkg.sv]
// constants, states and reset kinds shared by the reset and power-up sequencer
package rstseq_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS  = 100;
	// shortest external clear pulse that is honoured
	localparam int CLEAR_MIN_NS   = 2000;
	localparam int CLEAR_FILT_CYC = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_CNT_W     = 8;
	// startup delay, counted in periods of the internal rc oscillator
	localparam int DELAY_MS       = 72;
	localparam int RC_OSC_KHZ     = 32;
	localparam int DELAY_TICKS    = DELAY_MS * RC_OSC_KHZ;
	localparam int SETTLE_CYC     = 1024;
	localparam int CNT_W          = 16;

	// ****************************************************************
	// register map and layout
	// ****************************************************************
	localparam logic [3:0] ADDR_CAUSE  = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_MASK   = 4'h8;
	localparam int         EVT_W       = 6;
	localparam logic [5:0] MASK_RST    = 6'h00;
	localparam logic [5:0] STATUS_RST  = 6'h00;
	localparam int CAUSE_EXPIRED_BIT   = 0;
	localparam int CAUSE_SLEEP_BIT     = 1;
	localparam int CAUSE_KIND_LSB      = 2;

	// ****************************************************************
	// synchroniser lanes and oscillator modes
	// ****************************************************************
	localparam int SYNC_W         = 4;
	localparam int SYNC_CLEAR_N   = 0;
	localparam int SYNC_SUPPLY_OK = 1;
	localparam int SYNC_DIP       = 2;
	localparam int SYNC_RC        = 3;
	localparam logic [1:0] OSC_RESISTOR_CAP = 2'h3;

	typedef enum logic [1:0] {
		ST_RUN    = 2'h0,
		ST_HOLD   = 2'h1,
		ST_DELAY  = 2'h2,
		ST_SETTLE = 2'h3
	} rstseq_state_t;

	typedef enum logic [2:0] {
		K_NONE        = 3'h0,
		K_POWER_ON    = 3'h1,
		K_CLEAR_RUN   = 3'h2,
		K_CLEAR_SLEEP = 3'h3,
		K_WD_RESET    = 3'h4,
		K_WD_WAKE     = 3'h5,
		K_SUPPLY_DIP  = 3'h6
	} rstseq_kind_t;

endpackage : rstseq_pkg

// [src/rstseq_filter.sv]
// glitch filter on the synchronised external clear request
`timescale 1ns/100ps
module rstseq_filter (
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_level,
	output logic      o_level
);

	logic [rstseq_pkg::FILT_CNT_W-1:0] cnt_r;

	// output follows only after the input has differed for the full window
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r   <= 8'h00;
			o_level <= 1'b1;
		end else if (i_level == o_level) begin
			cnt_r <= 8'h00;
		end else if (cnt_r == 8'(rstseq_pkg::CLEAR_FILT_CYC - 1)) begin
			cnt_r   <= 8'h00;
			o_level <= i_level;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

endmodule : rstseq_filter

// [src/rstseq_sync.sv]
// two-flop synchroniser for the asynchronous pin levels
`timescale 1ns/100ps
module rstseq_sync (
	input  wire logic                           i_clk,
	input  wire logic                           i_reset,
	input  wire logic [rstseq_pkg::SYNC_W-1:0]  i_async,
	output logic      [rstseq_pkg::SYNC_W-1:0]  o_sync
);

	logic [rstseq_pkg::SYNC_W-1:0] meta_r;

	// first stage is read only by the second
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_r <= 4'h0;
			o_sync <= 4'h0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule : rstseq_sync

// [src/rstseq_top.sv]
// reset classification, power-up sequencing and divided clock output
`timescale 1ns/100ps
module rstseq_top #(
	parameter int p_delay_ticks = rstseq_pkg::DELAY_TICKS
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_external_clear_pin_n,
	input  wire logic       i_supply_ok,
	input  wire logic       i_supply_dip,
	input  wire logic       i_rc_osc,
	input  wire logic       i_watchdog_timeout,
	input  wire logic       i_sleeping,
	input  wire logic       i_delay_timer_disable_fuse,
	input  wire logic       i_supply_dip_enable_fuse,
	input  wire logic [1:0] i_osc_mode,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	output logic            o_chip_reset,
	output logic            o_reg_reset,
	output logic            o_power_on_reset,
	output logic      [2:0] o_reset_kind,
	output logic            o_watchdog_expired_flag,
	output logic            o_sleep_entered_flag,
	output logic            o_divided_clock_output,
	output logic            o_irq
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// crystal and resonator modes need the oscillator settle count
	function automatic logic is_crystal(input logic [1:0] mode);
		is_crystal = (mode != rstseq_pkg::OSC_RESISTOR_CAP);
	endfunction : is_crystal

	// one status bit per reset kind, kind 1 on bit 0
	function automatic logic [5:0] kind_bit(input logic [2:0] kind);
		logic [5:0] v;
		v = 6'h00;
		if (kind != 3'h0)
			v[kind - 3'h1] = 1'b1;
		kind_bit = v;
	endfunction : kind_bit

	// ****************************************************************
	// pin synchronisation and clear filter
	// ****************************************************************
	logic [rstseq_pkg::SYNC_W-1:0] sync_s;
	logic                          clear_f;

	rstseq_sync u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_rc_osc, i_supply_dip, i_supply_ok, i_external_clear_pin_n}),
		.o_sync  (sync_s)
	);

	rstseq_filter u_filter (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_level (~sync_s[rstseq_pkg::SYNC_CLEAR_N]),
		.o_level (clear_f)
	);

	// ****************************************************************
	// event detection
	// ****************************************************************
	logic ok_s;
	logic rc_s;
	logic dip_en;
	logic dip_hold;
	logic por_hold;
	logic delay_en;
	logic crystal;
	logic ok_d_r;
	logic rc_d_r;
	logic dip_d_r;
	logic clear_d_r;
	logic first_r;
	logic ev_por;
	logic ev_dip;
	logic ev_clear;
	logic rc_tick;
	logic wd_wake;

	assign ok_s     = sync_s[rstseq_pkg::SYNC_SUPPLY_OK];
	assign rc_s     = sync_s[rstseq_pkg::SYNC_RC];
	assign dip_en   = i_supply_dip_enable_fuse;
	assign dip_hold = dip_en & sync_s[rstseq_pkg::SYNC_DIP];
	// only the first climb of the supply is held; a later drop is ignored
	assign por_hold = first_r & ~ok_s;
	assign delay_en = ~i_delay_timer_disable_fuse | dip_en;
	assign crystal  = is_crystal(i_osc_mode);
	assign ev_por   = ok_s & ~ok_d_r;
	assign ev_dip   = dip_hold & ~dip_d_r;
	assign ev_clear = clear_f & ~clear_d_r;
	assign rc_tick  = rc_s & ~rc_d_r;
	assign wd_wake  = i_watchdog_timeout & i_sleeping;

	// previous values for edge detection
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ok_d_r    <= 1'b0;
			rc_d_r    <= 1'b0;
			dip_d_r   <= 1'b0;
			clear_d_r <= 1'b1; // filter leaves reset asserted, so no false clear edge
		end else begin
			ok_d_r    <= ok_s;
			rc_d_r    <= rc_s;
			dip_d_r   <= dip_hold;
			clear_d_r <= clear_f;
		end
	end

	// first power-up marker, cleared once the supply is good
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			first_r <= 1'b1;
		else if (ok_s)
			first_r <= 1'b0;
	end

	// ****************************************************************
	// reset kind of this cycle
	// ****************************************************************
	rstseq_pkg::rstseq_kind_t kind_now;

	// dip outranks power-on, which outranks clear and watchdog
	always_comb begin
		kind_now = rstseq_pkg::K_NONE;
		if (ev_dip)
			kind_now = rstseq_pkg::K_SUPPLY_DIP;
		else if (ev_por)
			kind_now = rstseq_pkg::K_POWER_ON;
		else if (ev_clear)
			kind_now = i_sleeping ? rstseq_pkg::K_CLEAR_SLEEP : rstseq_pkg::K_CLEAR_RUN;
		else if (i_watchdog_timeout)
			kind_now = i_sleeping ? rstseq_pkg::K_WD_WAKE : rstseq_pkg::K_WD_RESET;
	end

	// ****************************************************************
	// startup delay and oscillator settle sequencer
	// ****************************************************************
	rstseq_pkg::rstseq_state_t state_r;
	rstseq_pkg::rstseq_kind_t  seq_kind_r;
	logic [rstseq_pkg::CNT_W-1:0] cnt_r;
	logic settle_req;

	// settle follows a power-on or a wake, never a dip
	assign settle_req = crystal & (seq_kind_r != rstseq_pkg::K_SUPPLY_DIP);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r    <= rstseq_pkg::ST_HOLD;
			seq_kind_r <= rstseq_pkg::K_POWER_ON;
			cnt_r      <= 16'h0000;
		end else if (dip_hold) begin
			// a dip at any point throws the sequence back to the start
			state_r    <= rstseq_pkg::ST_HOLD;
			seq_kind_r <= rstseq_pkg::K_SUPPLY_DIP;
			cnt_r      <= 16'h0000;
		end else if (por_hold || (ev_por && state_r == rstseq_pkg::ST_RUN)) begin
			state_r    <= rstseq_pkg::ST_HOLD;
			seq_kind_r <= rstseq_pkg::K_POWER_ON;
			cnt_r      <= 16'h0000;
		end else begin
			case (state_r)
				rstseq_pkg::ST_HOLD: begin
					cnt_r <= 16'h0000;
					if (delay_en)
						state_r <= rstseq_pkg::ST_DELAY;
					else if (settle_req)
						state_r <= rstseq_pkg::ST_SETTLE;
					else
						state_r <= rstseq_pkg::ST_RUN;
				end
				rstseq_pkg::ST_DELAY: begin
					if (rc_tick && cnt_r == 16'(p_delay_ticks - 1)) begin
						cnt_r   <= 16'h0000;
						state_r <= settle_req ? rstseq_pkg::ST_SETTLE : rstseq_pkg::ST_RUN;
					end else if (rc_tick) begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				rstseq_pkg::ST_SETTLE: begin
					if (cnt_r == 16'(rstseq_pkg::SETTLE_CYC - 1)) begin
						cnt_r   <= 16'h0000;
						state_r <= rstseq_pkg::ST_RUN;
					end else begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				rstseq_pkg::ST_RUN: begin
					cnt_r <= 16'h0000;
					// a wake in a crystal mode waits for the oscillator again
					if (wd_wake && crystal) begin
						state_r    <= rstseq_pkg::ST_SETTLE;
						seq_kind_r <= rstseq_pkg::K_WD_WAKE;
					end
				end
				default: begin
					state_r <= rstseq_pkg::ST_HOLD;
					cnt_r   <= 16'h0000;
				end
			endcase
		end
	end

	// ****************************************************************
	// reset outputs
	// ****************************************************************
	logic seq_active;
	logic wd_rst_r;

	assign seq_active = (state_r != rstseq_pkg::ST_RUN);

	// watchdog reset in normal operation lasts as long as the timeout input, one cycle late
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			wd_rst_r <= 1'b0;
		else
			wd_rst_r <= i_watchdog_timeout & ~i_sleeping;
	end

	// registered so release always lands on a clock edge
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_chip_reset     <= 1'b1;
			o_reg_reset      <= 1'b1;
			o_power_on_reset <= 1'b1;
		end else begin
			o_chip_reset     <= por_hold | dip_hold | seq_active | clear_f | wd_rst_r;
			o_reg_reset      <= por_hold | dip_hold | clear_f | wd_rst_r
			                  | (seq_active & (seq_kind_r != rstseq_pkg::K_WD_WAKE));
			o_power_on_reset <= por_hold
			                  | (seq_active & (seq_kind_r == rstseq_pkg::K_POWER_ON));
		end
	end

	// ****************************************************************
	// reset cause flags
	// ****************************************************************
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_watchdog_expired_flag <= 1'b1;
			o_sleep_entered_flag    <= 1'b1;
			o_reset_kind            <= rstseq_pkg::K_POWER_ON;
		end else begin
			if (kind_now != rstseq_pkg::K_NONE)
				o_reset_kind <= kind_now;
			case (kind_now)
				rstseq_pkg::K_POWER_ON: begin
					o_watchdog_expired_flag <= 1'b1;
					o_sleep_entered_flag    <= 1'b1;
				end
				rstseq_pkg::K_WD_RESET: begin
					o_watchdog_expired_flag <= 1'b0;
				end
				rstseq_pkg::K_WD_WAKE: begin
					o_watchdog_expired_flag <= 1'b0;
					o_sleep_entered_flag    <= 1'b0;
				end
				rstseq_pkg::K_CLEAR_SLEEP: begin
					o_watchdog_expired_flag <= 1'b1;
					o_sleep_entered_flag    <= 1'b0;
				end
				default: begin
					// clear while running and dip leave both flags as they were
				end
			endcase
		end
	end

	// ****************************************************************
	// divided clock output
	// ****************************************************************
	logic [1:0] phase_r;
	logic [1:0] phase_nxt;

	assign phase_nxt = phase_r + 2'h1;

	// phase restarts with the chip so the output lines up with the cycle
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			phase_r                <= 2'h0;
			o_divided_clock_output <= 1'b0;
		end else if (o_chip_reset) begin
			phase_r                <= 2'h0;
			o_divided_clock_output <= 1'b0;
		end else begin
			phase_r                <= phase_nxt;
			o_divided_clock_output <= ~crystal & phase_nxt[1];
		end
	end

	// ****************************************************************
	// register port and interrupt
	// ****************************************************************
	logic [5:0] status_r;
	logic [5:0] mask_r;
	logic [5:0] clr_bits;

	assign clr_bits = (i_wr && i_addr == rstseq_pkg::ADDR_STATUS) ? i_wdata[5:0] : 6'h00;

	// a new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			status_r <= rstseq_pkg::STATUS_RST;
		else
			status_r <= (status_r & ~clr_bits) | kind_bit(kind_now);
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			mask_r <= rstseq_pkg::MASK_RST;
		else if (i_wr && i_addr == rstseq_pkg::ADDR_MASK)
			mask_r <= i_wdata[5:0];
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			o_irq <= 1'b0;
		else
			o_irq <= |(status_r & mask_r);
	end

	// read data one cycle after the strobe, zero otherwise and when unmapped
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				rstseq_pkg::ADDR_CAUSE:  o_rdata <= {3'h0, o_reset_kind, o_sleep_entered_flag,
				                                     o_watchdog_expired_flag};
				rstseq_pkg::ADDR_STATUS: o_rdata <= {2'h0, status_r};
				rstseq_pkg::ADDR_MASK:   o_rdata <= {2'h0, mask_r};
				default:                 o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

endmodule : rstseq_top

// [verif/rstseq_env_model.sv]
// far-side model: clear pin, supply monitors and the internal rc oscillator
`timescale 1ns/100ps
module rstseq_env_model (
	input  wire logic i_clear_cmd,
	input  wire logic i_supply_cmd,
	input  wire logic i_dip_cmd,
	output logic      o_clear_pin_n,
	output logic      o_supply_ok,
	output logic      o_supply_dip,
	output logic      o_rc_osc
);
	// ****************************************************************
	// pin and supply levels, skewed so their edges never meet the clock edge
	// ****************************************************************
	initial begin
		o_clear_pin_n = 1'b1;
		o_supply_ok = 1'b0;
		o_supply_dip = 1'b0;
	end
	// pin has a pull-up: released reads high
	always @(i_clear_cmd) o_clear_pin_n <= #37 !i_clear_cmd;
	always @(i_supply_cmd) o_supply_ok <= #41 i_supply_cmd;
	always @(i_dip_cmd) o_supply_dip <= #43 i_dip_cmd;
	// free-running rc oscillator, period 700 ns, unrelated to the main clock
	initial begin
		o_rc_osc = 1'b0;
		forever #350 o_rc_osc = !o_rc_osc;
	end
endmodule : rstseq_env_model

// [verif/rstseq_top_sva.sv]
// assertion checker on the ports of the reset and power-up sequencer
`timescale 1ns/100ps
module rstseq_top_chk #(
	parameter int p_delay_ticks = rstseq_pkg::DELAY_TICKS
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_external_clear_pin_n,
	input  wire logic       i_supply_ok,
	input  wire logic       i_supply_dip,
	input  wire logic       i_watchdog_timeout,
	input  wire logic       i_sleeping,
	input  wire logic [1:0] i_osc_mode,
	input  wire logic       o_chip_reset,
	input  wire logic       o_reg_reset,
	input  wire logic       o_power_on_reset,
	input  wire logic [2:0] o_reset_kind,
	input  wire logic       o_watchdog_expired_flag,
	input  wire logic       o_sleep_entered_flag,
	input  wire logic       o_divided_clock_output
);
	// ****************************************************************
	// port relations, all in the one clock domain
	// ****************************************************************
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (i_reset);

	kind_legal_a: assert property (o_reset_kind inside {[3'h1:3'h6]})
		else $error("reset kind outside the six kinds");
	divided_clock_output_idle_a: assert property (i_osc_mode != rstseq_pkg::OSC_RESISTOR_CAP
		&& $past(i_osc_mode) != rstseq_pkg::OSC_RESISTOR_CAP |-> !o_divided_clock_output)
		else $error("divided clock active outside rc mode");
	// a chip reset may restart the divider, so only whole running periods are judged
	divided_clock_output_phase_a: assert property (disable iff (i_reset || o_chip_reset)
		$rose(o_divided_clock_output) |-> o_divided_clock_output ##1 o_divided_clock_output
		##1 !o_divided_clock_output ##1 !o_divided_clock_output ##1 o_divided_clock_output)
		else $error("divided clock not two high two low");
	por_in_chip_a: assert property (o_power_on_reset |-> o_reg_reset && o_chip_reset)
		else $error("power-on reset without register and chip reset");
	por_flags_a: assert property ($fell(o_power_on_reset) |-> o_reset_kind == 3'h1
		&& o_watchdog_expired_flag && o_sleep_entered_flag)
		else $error("power-on ended without both flags set");
	wd_reset_a: assert property (i_watchdog_timeout && !i_sleeping && !o_chip_reset
		|-> ##[1:3] o_reset_kind == 3'h4 && !o_watchdog_expired_flag)
		else $error("watchdog reset not recorded");
	wd_wake_a: assert property (i_watchdog_timeout && i_sleeping && !o_chip_reset
		|-> ##[1:3] o_reset_kind == 3'h5 && !o_watchdog_expired_flag && !o_sleep_entered_flag)
		else $error("watchdog wake not recorded");
	wake_keeps_regs_a: assert property (i_watchdog_timeout && i_sleeping && !o_chip_reset
		|-> !o_reg_reset [*6])
		else $error("register reset on watchdog wake");
	supply_fall_a: assert property ($fell(i_supply_ok) && !o_chip_reset |-> !o_power_on_reset [*8])
		else $error("power-on reset on falling supply");
	// pin low for under eight cycles, far below the filter width
	glitch_filter_a: assert property ($rose(i_external_clear_pin_n) && $past(i_external_clear_pin_n, 8)
		&& !o_chip_reset && !i_supply_dip |-> !o_chip_reset [*8])
		else $error("short clear pulse caused reset");
endmodule : rstseq_top_chk

bind rstseq_top rstseq_top_chk #(.p_delay_ticks(p_delay_ticks)) u_chk (
	.i_clk(i_clk), .i_reset(i_reset), .i_external_clear_pin_n(i_external_clear_pin_n),
	.i_supply_ok(i_supply_ok), .i_supply_dip(i_supply_dip), .i_watchdog_timeout(i_watchdog_timeout),
	.i_sleeping(i_sleeping), .i_osc_mode(i_osc_mode), .o_chip_reset(o_chip_reset),
	.o_reg_reset(o_reg_reset), .o_power_on_reset(o_power_on_reset), .o_reset_kind(o_reset_kind),
	.o_watchdog_expired_flag(o_watchdog_expired_flag), .o_sleep_entered_flag(o_sleep_entered_flag),
	.o_divided_clock_output(o_divided_clock_output));

// [verif/rstseq_top_tb_top.sv]
// self-checking bench for the reset and power-up sequencer
`timescale 1ns/100ps
module rstseq_top_tb_top;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic       clear_cmd = 1'b0;
	logic       supply_cmd = 1'b0;
	logic       dip_cmd = 1'b0;
	logic       pin_n, supply_ok, dip, rc_osc;
	logic       wd = 1'b0;
	logic       sleeping = 1'b0;
	logic       dfuse = 1'b1;
	logic       dipfuse = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       bus_wr = 1'b0;
	logic       bus_rd = 1'b0;
	logic [7:0] rdata;
	logic [2:0] kind;
	logic       chip_rst, reg_rst, por, exp_f, slp_f, divided_clock_output, irq;
	int         errors = 0;
	int         tests_run = 0;

	// ****************************************************************
	// clock, design and far side
	// ****************************************************************
	initial forever #50 clk = !clk;

	rstseq_top #(.p_delay_ticks(4)) uut (.i_clk(clk), .i_reset(reset), .i_external_clear_pin_n(pin_n),
		.i_supply_ok(supply_ok), .i_supply_dip(dip), .i_rc_osc(rc_osc), .i_watchdog_timeout(wd),
		.i_sleeping(sleeping), .i_delay_timer_disable_fuse(dfuse), .i_supply_dip_enable_fuse(dipfuse),
		.i_osc_mode(mode), .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata),
		.o_chip_reset(chip_rst), .o_reg_reset(reg_rst), .o_power_on_reset(por), .o_reset_kind(kind),
		.o_watchdog_expired_flag(exp_f), .o_sleep_entered_flag(slp_f), .o_divided_clock_output(divided_clock_output),
		.o_irq(irq));

	rstseq_env_model env (.i_clear_cmd(clear_cmd), .i_supply_cmd(supply_cmd), .i_dip_cmd(dip_cmd),
		.o_clear_pin_n(pin_n), .o_supply_ok(supply_ok), .o_supply_dip(dip), .o_rc_osc(rc_osc));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// bounded wait for the chip reset to drop, counting cycles
	task automatic wait_rel(output int n);
		n = 0;
		while (chip_rst !== 1'b0 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_rel

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// full power-up under one configuration; release must land in [lo, hi]
	task automatic power_up(input logic [1:0] m, input logic df, input logic bf, input int lo, input int hi);
		int n;
		logic [7:0] d;
		@(posedge clk);
		reset <= 1'b1;
		supply_cmd <= 1'b0;
		mode <= m;
		dfuse <= df;
		dipfuse <= bf;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		cyc(50);
		chk("held without supply", chip_rst, 1'b1);
		@(posedge clk);
		supply_cmd <= 1'b1;
		wait_rel(n);
		chk("release window", n >= lo && n <= hi, 1'b1);
		chk("power-on cause", {exp_f, slp_f, kind}, 5'h19);
		reg_rd(4'h4, d);
		chk("power-on event only", d, 8'h01);
		$display("power up mode %0d released after %0d cycles", m, n);
	endtask : power_up

	task automatic t_divided_clock_output;
		int highs = 0;
		int rises = 0;
		logic prev;
		prev = divided_clock_output;
		repeat (16) begin
			cyc(1);
			highs += (divided_clock_output === 1'b1);
			rises += (divided_clock_output === 1'b1 && prev === 1'b0);
			prev = divided_clock_output;
		end
		chk("divided clock highs", highs, 8);
		chk("divided clock rises", rises, 4);
		$display("divided clock test done");
	endtask : t_divided_clock_output

	// short glitch, then clear while running and while sleeping
	task automatic t_clear;
		int n;
		@(posedge clk) clear_cmd <= 1'b1;
		repeat (6) @(posedge clk);
		clear_cmd <= 1'b0;
		cyc(40);
		chk("glitch ignored", chip_rst, 1'b0);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			sleeping <= s[0];
			clear_cmd <= 1'b1;
			repeat (30) @(posedge clk);
			clear_cmd <= 1'b0;
			sleeping <= 1'b0;
			#1 chk("clear cause", {chip_rst, exp_f, slp_f, kind}, {2'b11, !s[0], 3'(2 + s)});
			wait_rel(n);
			chk("no delay after clear", n < 40, 1'b1);
		end
		$display("external clear test done");
	endtask : t_clear

	// watchdog reset when running, wake with settle when sleeping
	task automatic t_watchdog;
		int n;
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			sleeping <= s[0];
			wd <= 1'b1;
			@(posedge clk);
			wd <= 1'b0;
			cyc(3);
			chk("watchdog cause", {exp_f, slp_f, kind}, {2'b00, 3'(4 + s)});
			wait_rel(n);
			chk("wake settle only", s ? (n > 1000 && n < 1030) : (n < 5), 1'b1);
			@(posedge clk) sleeping <= 1'b0;
		end
		$display("watchdog test done");
	endtask : t_watchdog

	// dip, then a second dip inside the running delay
	task automatic t_dip;
		int n;
		@(posedge clk) dip_cmd <= 1'b1;
		cyc(10);
		chk("dip cause", {chip_rst, kind}, 4'hE);
		@(posedge clk) dip_cmd <= 1'b0;
		cyc(12);
		chk("delay holds reset", chip_rst, 1'b1);
		@(posedge clk) dip_cmd <= 1'b1;
		cyc(4);
		@(posedge clk) dip_cmd <= 1'b0;
		wait_rel(n);
		chk("delay restarted", n >= 20 && n <= 45, 1'b1);
		@(posedge clk) supply_cmd <= 1'b0;
		cyc(30);
		chk("falling supply ignored", {chip_rst, por}, 2'b00);
		$display("supply dip test done");
	endtask : t_dip

	task automatic t_regs;
		logic [7:0] d;
		reg_rd(4'h4, d);
		chk("all six kinds seen", d, 8'h3F);
		reg_rd(4'h8, d);
		chk("mask reset value", d, 8'h00);
		chk("irq masked", irq, 1'b0);
		reg_wr(4'h8, 8'h20);
		cyc(2);
		chk("irq raised", irq, 1'b1);
		reg_wr(4'h4, 8'h1F);
		cyc(2);
		chk("irq held", irq, 1'b1);
		reg_wr(4'h4, 8'h20);
		cyc(2);
		chk("irq cleared", irq, 1'b0);
		reg_rd(4'h4, d);
		chk("status cleared", d, 8'h00);
		reg_wr(4'h0, 8'hFF);
		reg_rd(4'h0, d);
		chk("cause read only", d, 8'h18);
		reg_rd(4'hC, d);
		chk("unmapped read", d, 8'h00);
		$display("register test done");
	endtask : t_regs

	initial begin : main
		power_up(2'h1, 1'b1, 1'b0, 1024, 1036);
		power_up(2'h3, 1'b1, 1'b0, 1, 8);
		t_divided_clock_output();
		power_up(2'h3, 1'b1, 1'b1, 20, 45);
		// delay kept enabled alongside dip detection
		power_up(2'h0, 1'b0, 1'b1, 1044, 1069);
		t_clear();
		t_watchdog();
		t_dip();
		t_regs();
		end_of_test();
	end

	// run needs about 0.4 ms; five times that means a hang
	initial begin : watchdog_timer
		#2000000;
		errors++;
		end_of_test();
	end
endmodule : rstseq_top_tb_top
